//--- src/asg_pkg.sv
package asg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] STAT_ADDR  = 8'h00;
  localparam logic [7:0] CTRL_ADDR  = 8'h01;
  localparam logic [7:0] STAT_RESET = 8'h81;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control bits that hold a stored value
  localparam logic [7:0] CTRL_KEEP  = 8'hF6;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int ST_SEQ  = 6;
  localparam int ST_HS   = 5;
  localparam int ST_RMS  = 4;
  localparam int ST_AVG  = 3;
  localparam int ST_FUSE = 2;
  localparam int ST_CERR = 1;
  localparam int ST_BROWN = 0;

  // ****************************************
  // Control bit positions
  // ****************************************
  localparam int CT_RMS   = 7;
  localparam int CT_CRC   = 6;
  localparam int CT_STATS = 5;
  localparam int CT_WIN   = 4;
  localparam int CT_KICK  = 3;
  localparam int CT_FORCE = 2;
  localparam int CT_CAL   = 1;
  localparam int CT_RST   = 0;

  // ****************************************
  // Serial framing constants
  // ****************************************
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_END  = 4'h9;
  localparam logic [4:0] HS_CODE  = 5'h01;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Serial front end states, Gray along the write path
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_WPTR = 3'b011,
    S_WDAT = 3'b010,
    S_WCRC = 3'b110,
    S_RDAT = 3'b111,
    S_RCRC = 3'b101
  } asg_state_t;

  // CRC-8 over one byte, MSB first
  function automatic logic [7:0] asg_crc8(input logic [7:0] d);
    logic [7:0] c;
    c = CRC_INIT ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction

endpackage

//--- src/asg_regs.sv
// Contract
// - Status bit 6 mirrors sequencer running
// - Status bit 5 shows high-speed bus mode
// - RMS ready flag sets, write-one clears
// - Averaging ready flag sets, write-one clears
// - Config check fail re-read on reset
// - Input CRC error flag, write-one clears
// - CRC error blocks writes beyond 0x00/0x01
// - Brownout flag resets to 1, write-one clears
// - RMS enable; writing 1 restarts RMS
// - CRC enable appends and checks CRC
// - Stats enable; writing 1 clears stats
// - Window comparator enable, else held reset
// - Frame conversion on 9th fall, stretch
// - Kick starts conversion without stretching
// - Kick bit always reads zero
// - Force all channels to analog inputs
// - Calibration bit self-clears when done
// - Soft reset restores defaults, sets brownout
// - Halt on CRC error forces analog, pauses
module asg_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  // Clocks and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_scl_clk,
  // Serial pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_scl_out,
  output logic            o_scl_oe,
  // Unit status inputs
  input  wire logic       i_seq_running,
  input  wire logic       i_rms_finish,
  input  wire logic       i_avg_done,
  input  wire logic       i_cfg_check_fail,
  input  wire logic       i_brownout,
  input  wire logic       i_cal_done,
  input  wire logic       i_conv_busy,
  input  wire logic       i_halt_on_check_fail,
  // Unit controls
  output logic            o_rms_enable,
  output logic            o_rms_restart,
  output logic            o_crc_enable,
  output logic            o_stats_enable,
  output logic            o_stats_clear,
  output logic            o_win_enable,
  output logic            o_conv_kick,
  output logic            o_frame_conv,
  output logic            o_force_analog,
  output logic            o_seq_pause,
  output logic            o_cal_start,
  output logic            o_soft_reset,
  // Writes to registers outside this bank
  output logic            o_ext_wr,
  output logic [7:0]      o_ext_addr,
  output logic [7:0]      o_ext_data
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic               scl_q1;   // Pin synchroniser stage 1
    logic               scl_q2;   // Pin synchroniser stage 2
    logic               scl_d;    // Previous synced level
    logic               sda_q1;
    logic               sda_q2;
    logic               sda_d;
    asg_pkg::asg_state_t st;      // Front end state
    logic [3:0]         bitcnt;   // Rising edges in byte
    logic               txing;    // Byte being sent
    logic               ack_pend; // Acknowledge next slot
    logic               hs;       // High-speed mode
    logic               fpend;    // Frame conversion due
    logic [7:0]         ptr;      // Register pointer
    logic [7:0]         hold;     // Last data byte
    logic [7:0]         tx;       // Transmit shifter
    logic               sda_oe;
    logic               scl_oe;
    logic               rms;      // Status flags
    logic               avg;
    logic               cerr;
    logic               brown;
    logic               fuse;
    logic               fuse_pend;
    logic [7:0]         ctrl;     // Stored control bits
    logic               rms_rs;   // One-cycle pulses, write target, levels
    logic               st_clr;
    logic               kick;
    logic               fconv;
    logic               cal_go;
    logic               srst;
    logic               ext_wr;
    logic [7:0]         ext_addr;
    logic [7:0]         ext_data;
    logic               force_a;
    logic               pause;
  } asg_regs_t;

  typedef struct packed {
    logic [7:0] shift;            // Bits taken on SCL rise
  } asg_link_t;

  asg_regs_t r;
  asg_regs_t n;
  asg_link_t lk;
  asg_link_t lk_nxt;

  logic rise;
  logic fall;
  logic start;
  logic stop;

  // Edges and bus conditions from synced levels
  assign rise  = r.scl_q2 & ~r.scl_d;
  assign fall  = ~r.scl_q2 & r.scl_d;
  assign start = r.scl_q2 & r.scl_d & r.sda_d & ~r.sda_q2;
  assign stop  = r.scl_q2 & r.scl_d & ~r.sda_d & r.sda_q2;

  // ****************************************
  // Link domain: shift in data bits
  // ****************************************
  // The shifter only changes on an SCL rise; the
  // reference side reads it while SCL stays high.
  always_comb begin
    lk_nxt = lk;
    lk_nxt.shift = {lk.shift[6:0], i_sda};
  end

  always_ff @(posedge i_scl_clk) begin
    lk <= lk_nxt;
  end

  // Register read image
  function automatic logic [7:0] rd(input logic [7:0] a,
                                    input asg_regs_t s);
    logic [7:0] v;
    v = 8'h00;
    if (a == asg_pkg::STAT_ADDR) begin
      v = asg_pkg::STAT_RESET & 8'h80;
      v[asg_pkg::ST_SEQ]  = i_seq_running;
      v[asg_pkg::ST_HS]   = s.hs;
      v[asg_pkg::ST_RMS]  = s.rms;
      v[asg_pkg::ST_AVG]  = s.avg;
      v[asg_pkg::ST_FUSE] = s.fuse;
      v[asg_pkg::ST_CERR] = s.cerr;
      v[asg_pkg::ST_BROWN] = s.brown;
    end else if (a == asg_pkg::CTRL_ADDR) begin
      // Kick and reset bits read zero
      v = s.ctrl & asg_pkg::CTRL_KEEP;
    end
    return v;
  endfunction

  // ****************************************
  // Reference domain next state
  // ****************************************
  always_comb begin
    logic       wr;
    logic [7:0] wa;
    logic [7:0] wd;
    logic       cerr_set;
    logic [7:0] b;
    wr       = 1'b0;
    wa       = 8'h00;
    wd       = 8'h00;
    cerr_set = 1'b0;
    b        = lk.shift;
    n        = r;
    // Two-stage pin synchronisers
    n.scl_q1 = i_scl;
    n.scl_q2 = r.scl_q1;
    n.scl_d  = r.scl_q2;
    n.sda_q1 = i_sda;
    n.sda_q2 = r.sda_q1;
    n.sda_d  = r.sda_q2;
    // Pulses default low
    n.rms_rs = 1'b0;
    n.st_clr = 1'b0;
    n.kick   = 1'b0;
    n.fconv  = 1'b0;
    n.cal_go = 1'b0;
    n.srst   = 1'b0;
    n.ext_wr = 1'b0;

    // Serial front end
    if (start) begin
      n.st       = asg_pkg::S_ADDR;
      n.bitcnt   = 4'h0;
      n.txing    = 1'b0;
      n.ack_pend = 1'b0;
      n.sda_oe   = 1'b0;
    end else if (stop) begin
      n.st       = asg_pkg::S_IDLE;
      n.bitcnt   = 4'h0;
      n.txing    = 1'b0;
      n.hs       = 1'b0;
      n.sda_oe   = 1'b0;
    end else if (rise) begin
      n.bitcnt = r.bitcnt + 4'h1;
      if (r.bitcnt == asg_pkg::BIT_LAST && !r.txing) begin
        // Whole byte received
        unique case (r.st)
          asg_pkg::S_IDLE: begin
          end
          asg_pkg::S_ADDR: begin
            if (b[7:3] == asg_pkg::HS_CODE) begin
              n.hs = 1'b1;
              n.st = asg_pkg::S_IDLE;
            end else if (b[7:1] == DEV_ADDR) begin
              n.ack_pend = 1'b1;
              n.fpend    = b[0];
              n.st = b[0] ? asg_pkg::S_RDAT : asg_pkg::S_WPTR;
            end else begin
              n.st = asg_pkg::S_IDLE;
            end
          end
          asg_pkg::S_WPTR: begin
            n.ptr      = b;
            n.ack_pend = 1'b1;
            n.st       = asg_pkg::S_WDAT;
          end
          asg_pkg::S_WDAT: begin
            n.ack_pend = 1'b1;
            n.hold     = b;
            if (r.ctrl[asg_pkg::CT_CRC]) begin
              n.st = asg_pkg::S_WCRC;
            end else begin
              wr    = 1'b1;
              wa    = r.ptr;
              wd    = b;
              n.ptr = r.ptr + 8'h01;
            end
          end
          asg_pkg::S_WCRC: begin
            n.ack_pend = 1'b1;
            n.st       = asg_pkg::S_WDAT;
            if (b == asg_pkg::asg_crc8(r.hold)) begin
              wr    = 1'b1;
              wa    = r.ptr;
              wd    = r.hold;
              n.ptr = r.ptr + 8'h01;
            end else begin
              cerr_set = 1'b1;
            end
          end
          asg_pkg::S_RDAT, asg_pkg::S_RCRC: begin
          end
          default: begin
            n.st = asg_pkg::S_IDLE;
          end
        endcase
      end else if (r.bitcnt == asg_pkg::BIT_ACK && r.txing) begin
        // Master acknowledge of a sent byte
        if (r.sda_q2) begin
          n.st    = asg_pkg::S_IDLE;
          n.txing = 1'b0;
        end else if (r.st == asg_pkg::S_RDAT &&
                     r.ctrl[asg_pkg::CT_CRC]) begin
          n.st = asg_pkg::S_RCRC;
        end else begin
          n.st  = asg_pkg::S_RDAT;
          n.ptr = r.ptr + 8'h01;
        end
      end
    end else if (fall) begin
      if (r.bitcnt == asg_pkg::BIT_ACK) begin
        // Acknowledge slot
        n.sda_oe = r.ack_pend;
      end else if (r.bitcnt == asg_pkg::BIT_END) begin
        // Byte boundary
        n.bitcnt   = 4'h0;
        n.sda_oe   = 1'b0;
        n.ack_pend = 1'b0;
        n.txing    = 1'b0;
        if (r.fpend) begin
          n.fpend  = 1'b0;
          n.fconv  = 1'b1;
          n.scl_oe = 1'b1;
        end
        if (r.st == asg_pkg::S_RDAT) begin
          n.tx     = rd(r.ptr, r);
          n.hold   = n.tx;
          n.txing  = 1'b1;
          n.sda_oe = ~n.tx[7];
        end else if (r.st == asg_pkg::S_RCRC) begin
          n.tx     = asg_pkg::asg_crc8(r.hold);
          n.txing  = 1'b1;
          n.sda_oe = ~n.tx[7];
        end
      end else if (r.txing && r.bitcnt != 4'h0) begin
        // Next data bit, open drain
        n.tx     = {r.tx[6:0], 1'b0};
        n.sda_oe = ~r.tx[6];
      end
    end

    // Hold SCL low until the conversion ends
    if (r.scl_oe && !r.fconv && !i_conv_busy) begin
      n.scl_oe = 1'b0;
    end

    // Calibration completes
    if (i_cal_done) begin
      n.ctrl[asg_pkg::CT_CAL] = 1'b0;
    end

    // ****************************************
    // Register writes
    // ****************************************
    if (wr && wa == asg_pkg::STAT_ADDR) begin
      // Only ones clear; read-only bits ignored
      if (wd[asg_pkg::ST_RMS]) n.rms = 1'b0;
      if (wd[asg_pkg::ST_AVG]) n.avg = 1'b0;
      if (wd[asg_pkg::ST_CERR]) n.cerr = 1'b0;
      if (wd[asg_pkg::ST_BROWN]) n.brown = 1'b0;
    end else if (wr && wa == asg_pkg::CTRL_ADDR) begin
      n.ctrl   = wd & asg_pkg::CTRL_KEEP;
      n.rms_rs = wd[asg_pkg::CT_RMS];
      n.st_clr = wd[asg_pkg::CT_STATS];
      n.kick   = wd[asg_pkg::CT_KICK];
      n.cal_go = wd[asg_pkg::CT_CAL];
      n.srst   = wd[asg_pkg::CT_RST];
    end else if (wr && !r.cerr) begin
      n.ext_wr   = 1'b1;
      n.ext_addr = wa;
      n.ext_data = wd;
    end

    // Soft reset restores the bank defaults
    if (n.srst) begin
      n.ctrl      = asg_pkg::CTRL_RESET;
      n.rms       = asg_pkg::STAT_RESET[asg_pkg::ST_RMS];
      n.avg       = asg_pkg::STAT_RESET[asg_pkg::ST_AVG];
      n.cerr      = asg_pkg::STAT_RESET[asg_pkg::ST_CERR];
      n.brown     = 1'b1;
      n.fuse_pend = 1'b1;
      n.rms_rs    = 1'b0;
      n.st_clr    = 1'b0;
      n.kick      = 1'b0;
      n.cal_go    = 1'b0;
    end

    // Hardware events win over a same-cycle clear
    if (i_rms_finish) n.rms = 1'b1;
    if (i_avg_done) n.avg = 1'b1;
    if (cerr_set) n.cerr = 1'b1;
    if (i_brownout) n.brown = 1'b1;

    // Configuration check sampled after reset
    if (r.fuse_pend) begin
      n.fuse      = i_cfg_check_fail;
      n.fuse_pend = 1'b0;
    end

    // Channel forcing and sequencer pause
    n.pause   = i_halt_on_check_fail & n.cerr;
    n.force_a = n.ctrl[asg_pkg::CT_FORCE] | n.pause;
  end

  // ****************************************
  // Reference domain registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      r           <= '0;
      r.scl_q1    <= 1'b1;
      r.scl_q2    <= 1'b1;
      r.scl_d     <= 1'b1;
      r.sda_q1    <= 1'b1;
      r.sda_q2    <= 1'b1;
      r.sda_d     <= 1'b1;
      r.st        <= asg_pkg::S_IDLE;
      r.ctrl      <= asg_pkg::CTRL_RESET;
      r.brown     <= asg_pkg::STAT_RESET[asg_pkg::ST_BROWN];
      r.fuse_pend <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs from flops, bus pin levels tied low
  // ****************************************
  assign o_sda_out      = 1'b0;
  assign o_scl_out      = 1'b0;
  assign o_sda_oe       = r.sda_oe;
  assign o_scl_oe       = r.scl_oe;
  assign o_rms_enable   = r.ctrl[asg_pkg::CT_RMS];
  assign o_rms_restart  = r.rms_rs;
  assign o_crc_enable   = r.ctrl[asg_pkg::CT_CRC];
  assign o_stats_enable = r.ctrl[asg_pkg::CT_STATS];
  assign o_stats_clear  = r.st_clr;
  assign o_win_enable   = r.ctrl[asg_pkg::CT_WIN];
  assign o_conv_kick    = r.kick;
  assign o_frame_conv   = r.fconv;
  assign o_force_analog = r.force_a;
  assign o_seq_pause    = r.pause;
  assign o_cal_start    = r.cal_go;
  assign o_soft_reset   = r.srst;
  assign o_ext_wr       = r.ext_wr;
  assign o_ext_addr     = r.ext_addr;
  assign o_ext_data     = r.ext_data;

endmodule // asg_regs

//--- bench/asg_regs_monitor.sv
module asg_regs_monitor (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Watched inputs
  input  wire logic       i_conv_busy,
  input  wire logic       i_halt_on_check_fail,
  // Watched outputs
  input  wire logic       o_scl_oe,
  input  wire logic       o_rms_enable,
  input  wire logic       o_rms_restart,
  input  wire logic       o_crc_enable,
  input  wire logic       o_stats_enable,
  input  wire logic       o_stats_clear,
  input  wire logic       o_win_enable,
  input  wire logic       o_conv_kick,
  input  wire logic       o_frame_conv,
  input  wire logic       o_force_analog,
  input  wire logic       o_seq_pause,
  input  wire logic       o_cal_start,
  input  wire logic       o_soft_reset,
  input  wire logic       o_ext_wr,
  input  wire logic [7:0] o_ext_addr
);
  // ****************************************
  // Properties on the reference clock
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Kick and calibration starts are single pulses
  property p_kick;  o_conv_kick |=> !o_conv_kick; endproperty
  property p_cal;   o_cal_start |=> !o_cal_start; endproperty
  // Restart pulses come with the unit enabled
  property p_rms;   o_rms_restart |-> ##[0:1] o_rms_enable; endproperty
  property p_stats; o_stats_clear |-> ##[0:1] o_stats_enable; endproperty
  // Soft reset drowns the restart, clear, kick and calibration pulses and clears the enables
  property p_rst_quiet;
    o_soft_reset |-> !(o_rms_restart || o_stats_clear || o_conv_kick
                       || o_cal_start);
  endproperty
  property p_rst_clear;
    o_soft_reset |-> ##[0:2] !(o_rms_enable || o_crc_enable
                               || o_stats_enable || o_win_enable);
  endproperty
  // A paused sequencer always sees forced analog inputs
  property p_pause;  o_seq_pause |-> o_force_analog; endproperty
  property p_nohalt; !i_halt_on_check_fail [*3] |-> !o_seq_pause; endproperty
  // Frame conversion holds the clock low until busy drops
  property p_stretch; o_frame_conv |-> ##[0:1] o_scl_oe; endproperty
  property p_release; $fell(i_conv_busy) |-> ##[1:3] !o_scl_oe; endproperty
  // Writes never reach the neighbours while the sequencer is paused
  property p_gate; o_seq_pause |-> !o_ext_wr; endproperty

  a_kick: assert property (p_kick) else $error("kick not a pulse");
  a_cal: assert property (p_cal) else $error("cal not a pulse");
  a_rms: assert property (p_rms) else $error("rms restart off");
  a_stats: assert property (p_stats) else $error("stats clr off");
  a_rst_quiet: assert property (p_rst_quiet) else $error("rst pulse");
  a_rst_clear: assert property (p_rst_clear) else $error("rst enab");
  a_pause: assert property (p_pause) else $error("pause no force");
  a_nohalt: assert property (p_nohalt) else $error("pause no halt");
  a_stretch: assert property (p_stretch) else $error("no stretch");
  a_release: assert property (p_release) else $error("no release");
  a_gate: assert property (p_gate) else $error("blocked write out");

  // Main scenarios
  c_frame: cover property (o_frame_conv);
  c_reset: cover property (o_soft_reset);
  c_ext:   cover property (o_ext_wr);
endmodule // asg_regs_monitor

bind asg_regs asg_regs_monitor u_mon (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_conv_busy(i_conv_busy),
  .i_halt_on_check_fail(i_halt_on_check_fail), .o_scl_oe(o_scl_oe),
  .o_rms_enable(o_rms_enable), .o_rms_restart(o_rms_restart),
  .o_crc_enable(o_crc_enable), .o_stats_enable(o_stats_enable),
  .o_stats_clear(o_stats_clear), .o_win_enable(o_win_enable),
  .o_conv_kick(o_conv_kick), .o_frame_conv(o_frame_conv),
  .o_force_analog(o_force_analog), .o_seq_pause(o_seq_pause),
  .o_cal_start(o_cal_start), .o_soft_reset(o_soft_reset),
  .o_ext_wr(o_ext_wr), .o_ext_addr(o_ext_addr)
);

//--- bench/asg_host.sv
module asg_host (
  // Bus wire levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Open-drain pull-downs of the host
  output logic      o_scl_low,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  logic lclk;  // Host bit clock, 30 ns, own phase

  // Bit clock and idle bus
  initial begin
    lclk = 1'b0;
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end

  // Wait some host ticks
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask

  // One bit: data set while SCL low, sampled in the high phase
  task automatic put_bit(input logic b, output logic seen);
    o_sda_low <= !b;
    tick(5);
    o_scl_low <= 1'b0;
    tick(1);
    while (!i_scl) tick(1);  // Device holds SCL low
    seen = i_sda;
    tick(4);
    o_scl_low <= 1'b1;
  endtask

  // Start or repeated start
  task automatic start();
    o_sda_low <= 1'b0;
    tick(5);
    o_scl_low <= 1'b0;
    tick(5);
    o_sda_low <= 1'b1;
    tick(5);
    o_scl_low <= 1'b1;
  endtask

  // Stop, bus left released
  task automatic stop();
    o_sda_low <= 1'b1;
    tick(5);
    o_scl_low <= 1'b0;
    tick(5);
    o_sda_low <= 1'b0;
    tick(5);
  endtask

  // Byte out MSB first, ack returned
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask

  // Byte in MSB first, then ack or nack when last
  task automatic recv(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(last, s);
  endtask
endmodule // asg_host

//--- bench/asg_regs_test.sv
module asg_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] DEV = 7'h10;  // Bus address of the bank

  // Stimulus and wires
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       seq_run = 1'b0;
  logic       rms_fin = 1'b0;
  logic       avg_done = 1'b0;
  logic       cfg_fail = 1'b0;
  logic       brown_ev = 1'b0;
  logic       cal_done = 1'b0;
  logic       halt = 1'b0;
  logic [4:0] busy_cnt = 5'd0;
  logic       crc_on = 1'b0;
  wire        conv_busy = (busy_cnt != 5'd0);
  wire        scl_w, sda_w;
  logic       scl_low, sda_low, scl_oe, sda_oe, frame_conv, ext_wr;
  logic       pause, rms_on, crc_en, st_en, win_en, force_an;
  logic       rs_p, sc_p, kick_p, cal_p, srst_p, ack_hs;
  logic [5:0] pulses = 6'h00;  // Sticky record of each pulse output except ext_wr
  logic [7:0] ext_addr, ext_data, ext_d;
  int         ext_n = 0;
  int         fail_count = 0;
  int         samples_checked = 0;

  // Open-drain wires with pull-ups
  assign scl_w = !(scl_low | scl_oe);
  assign sda_w = !(sda_low | sda_oe);

  initial forever #12.5 clk = ~clk;

  asg_host host (.i_scl(scl_w), .i_sda(sda_w), .o_scl_low(scl_low),
                 .o_sda_low(sda_low));

  asg_regs #(.DEV_ADDR(DEV)) dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_scl_clk(scl_w), .i_scl(scl_w),
    .i_sda(sda_w), .o_sda_out(), .o_sda_oe(sda_oe), .o_scl_out(),
    .o_scl_oe(scl_oe), .i_seq_running(seq_run), .i_rms_finish(rms_fin),
    .i_avg_done(avg_done), .i_cfg_check_fail(cfg_fail),
    .i_brownout(brown_ev), .i_cal_done(cal_done), .i_conv_busy(conv_busy),
    .i_halt_on_check_fail(halt), .o_rms_enable(rms_on),
    .o_rms_restart(rs_p), .o_crc_enable(crc_en), .o_stats_enable(st_en),
    .o_stats_clear(sc_p), .o_win_enable(win_en), .o_conv_kick(kick_p),
    .o_frame_conv(frame_conv), .o_force_analog(force_an),
    .o_seq_pause(pause), .o_cal_start(cal_p), .o_soft_reset(srst_p),
    .o_ext_wr(ext_wr), .o_ext_addr(ext_addr), .o_ext_data(ext_data));

  // Converter model: busy for a while after each frame conversion
  always @(posedge clk) begin
    if (frame_conv) busy_cnt <= 5'd12;
    else if (busy_cnt != 5'd0) busy_cnt <= busy_cnt - 5'd1;
    pulses <= pulses | {frame_conv, rs_p, sc_p, kick_p, cal_p, srst_p};
    if (ext_wr && ext_addr == 8'h05) begin
      ext_n <= ext_n + 1;
      ext_d <= ext_data;
    end
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // CRC-8 of one byte, MSB first
  function automatic logic [7:0] crc_of(input logic [7:0] d);
    logic [7:0] c;
    c = asg_pkg::CRC_INIT ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ asg_pkg::CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Register write, optionally with a corrupted CRC byte
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic bad);
    logic a;
    host.start();
    host.send({DEV, 1'b0}, a);
    host.send(p, a);
    host.send(d, a);
    if (crc_on) host.send(crc_of(d) ^ {7'h00, bad}, a);
    host.stop();
  endtask

  // Register read through a repeated start
  task automatic rd(input logic [7:0] p, input logic [7:0] want);
    logic       a;
    logic [7:0] d;
    logic [7:0] c;
    host.start();
    host.send({DEV, 1'b0}, a);
    host.send(p, a);
    host.start();
    host.send({DEV, 1'b1}, a);
    host.recv(!crc_on, d);
    if (crc_on) begin
      host.recv(1'b1, c);
      check(c, crc_of(d));
    end
    host.stop();
    check(d, want);
  endtask

  // Counts, verdict, end of run
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(asg_pkg::STAT_ADDR, 8'h81);
    rd(asg_pkg::CTRL_ADDR, 8'h00);
    $display("Test reset values done");
    wr(asg_pkg::CTRL_ADDR, 8'hBE, 1'b0);
    rd(asg_pkg::CTRL_ADDR, 8'hB6);
    check({3'b000, rms_on, crc_en, st_en, win_en, force_an}, 8'h17);
    check({2'b00, pulses}, 8'h3E);
    @(posedge clk);
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    rd(asg_pkg::CTRL_ADDR, 8'hB4);
    $display("Test control done");
    @(posedge clk);
    rms_fin <= 1'b1;
    avg_done <= 1'b1;
    seq_run <= 1'b1;
    @(posedge clk);
    rms_fin <= 1'b0;
    avg_done <= 1'b0;
    rd(asg_pkg::STAT_ADDR, 8'hD9);
    wr(asg_pkg::STAT_ADDR, 8'h00, 1'b0);
    rd(asg_pkg::STAT_ADDR, 8'hD9);
    wr(asg_pkg::STAT_ADDR, 8'hFF, 1'b0);
    rd(asg_pkg::STAT_ADDR, 8'hC0);
    @(posedge clk);
    seq_run <= 1'b0;
    brown_ev <= 1'b1;
    @(posedge clk);
    brown_ev <= 1'b0;
    rd(asg_pkg::STAT_ADDR, 8'h81);
    wr(asg_pkg::STAT_ADDR, 8'h01, 1'b0);
    // Master code enters high-speed mode, kept over the repeated start
    host.start();
    host.send(8'h08, ack_hs);
    check({7'h00, ack_hs}, 8'h00);
    rd(asg_pkg::STAT_ADDR, 8'hA0);
    $display("Test status done");
    wr(asg_pkg::CTRL_ADDR, 8'h40, 1'b0);
    crc_on = 1'b1;
    @(posedge clk);
    halt <= 1'b1;
    wr(8'h05, 8'h3C, 1'b1);
    check({6'h00, pause, force_an}, 8'h03);
    wr(8'h05, 8'h3C, 1'b0);
    check(ext_n[7:0], 8'h00);
    rd(asg_pkg::STAT_ADDR, 8'h82);
    wr(asg_pkg::STAT_ADDR, 8'h02, 1'b0);
    wr(8'h05, 8'h3C, 1'b0);
    check(ext_n[7:0], 8'h01);
    check(ext_d, 8'h3C);
    check({6'h00, pause, force_an}, 8'h00);
    $display("Test input check done");
    @(posedge clk);
    cfg_fail <= 1'b1;
    wr(asg_pkg::CTRL_ADDR, 8'h01, 1'b0);
    crc_on = 1'b0;
    @(posedge clk);
    cfg_fail <= 1'b0;
    rd(asg_pkg::CTRL_ADDR, 8'h00);
    rd(asg_pkg::STAT_ADDR, 8'h85);
    check({2'b00, pulses}, 8'h3F);
    $display("Test soft reset done");
    complete_run();
  end
endmodule // asg_regs_test
